// ### irq_priority_pick.sv
// Shared constants and the rotating priority picker used by both interrupt units
`default_nettype none

package irq_pkg;
	// ------------------------------------------------------------
	// I/O decode
	// ------------------------------------------------------------
	localparam logic [9:0] MASTER_BASE = 10'h020; // Master even/odd pair
	localparam logic [9:0] SLAVE_BASE = 10'h0A0; // Slave even/odd pair
	localparam int UNITS = 2; // Master is unit 0, slave unit 1
	// ------------------------------------------------------------
	// Command bit positions
	// ------------------------------------------------------------
	localparam int INIT_BIT = 4; // Even write: start of init sequence
	localparam int SEL3_BIT = 3; // Even write: word three vs two
	localparam int LTM_BIT = 3; // First init word: level trigger
	localparam int AUTO_SERVICE_DONE_MODE_BIT = 1; // Fourth init word: auto done (active 0)
	localparam int ROT_BIT = 7; // Operation word two: rotate
	localparam int SPEC_BIT = 6; // Operation word two: specific
	localparam int DONE_BIT = 5; // Operation word two: service done
	localparam int ESMM_BIT = 6; // Word three: special mask enable
	localparam int SMM_BIT = 5; // Word three: special mask value
	localparam int RR_BIT = 1; // Word three: read select enable
	localparam int RIS_BIT = 0; // Word three: read in-service
	// ------------------------------------------------------------
	// Cascade and reset values
	// ------------------------------------------------------------
	localparam logic [2:0] CASCADE_CHAN = 3'h2; // Master input fed by slave
	localparam logic [2:0] SPURIOUS_CHAN = 3'h7; // Channel given when none pending
	localparam logic [2:0] LOWEST_RESET = 3'h7; // Channel 7 lowest, 0 highest
	localparam logic [7:0] SET_RESET = 8'h00; // Empty request/service/mask sets
	// Per-unit programmed state
	typedef struct packed {
		logic [4:0] vbase; // Vector base bits
		logic [2:0] id; // Cascade identifier
		logic ltm; // Level triggered inputs
		logic auto_service_done_mode; // Auto service done mode
		logic smm; // Special mask mode
		logic rd_isr; // Even read shows in-service set
		logic rot_auto_service_done_mode; // Rotate on every auto service done
		logic [2:0] lowest; // Lowest priority channel
		logic [1:0] step; // Init words still expected
	} unit_cfg_t;
	localparam unit_cfg_t CFG_RESET = '{5'h00, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
		LOWEST_RESET, 2'h0};
	// Acknowledge sequence phase
	typedef enum logic [0:0] {
		ACK_FIRST = 1'b0,
		ACK_SECOND = 1'b1
	} ack_phase_t;
endpackage

module irq_priority_pick (
	// Candidate set and rotation point
	input wire logic [7:0] vec_in,
	input wire logic [2:0] lowest_in,
	// Winner
	output logic found_out,
	output logic [2:0] chan_out,
	output logic [2:0] rank_out
);
	import irq_pkg::*;

	// --------------------------------------------------------------
	// Scan from rank 7 down to rank 0; lowest rank is highest priority
	// --------------------------------------------------------------
	always_comb begin
		logic [2:0] c;
		c = 3'h0;
		found_out = 1'b0;
		chan_out = 3'h0;
		rank_out = 3'h0;
		for (int k = 7; k >= 0; k--) begin
			c = 3'(lowest_in + 3'h1 + 3'(k));
			// Later hits have better rank and overwrite earlier ones
			if (vec_in[c]) begin
				found_out = 1'b1;
				chan_out = c;
				rank_out = 3'(k);
			end
		end
	end
endmodule

`default_nettype wire

// ### cascaded_irq_controller.sv
// Master and slave interrupt units in cascade behind an I/O port and acknowledge strobe
`default_nettype none

module cascaded_irq_controller (
	// Clock, reset, enable
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	// Request sources
	input wire logic timer_out0_in,
	input wire logic rtc_irq_in,
	input wire logic [15:0] ext_req_in,
	// Register port
	input wire logic [9:0] io_addr_in,
	input wire logic [7:0] io_wdata_in,
	input wire logic io_wr_in,
	input wire logic io_rd_in,
	// Acknowledge strobe, one per acknowledge cycle
	input wire logic ack_in,
	// Host data bus and request
	output logic [7:0] host_data_bus_out,
	output logic host_data_oe_out,
	output logic cpu_request_out
);
	import irq_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Port pair decode for one unit
	function automatic logic unit_hit(input logic [9:0] a, input int u);
		logic [9:0] base;
		base = (u == 0) ? MASTER_BASE : SLAVE_BASE;
		return a[9:1] == base[9:1];
	endfunction

	// One-hot of a channel number
	function automatic logic [7:0] onehot(input logic [2:0] c);
		return 8'h01 << c;
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] irr_q [UNITS]; // Pending sets
	logic [7:0] isr_q [UNITS]; // In-service sets
	logic [7:0] imr_q [UNITS]; // Mask sets
	logic [7:0] prev_q [UNITS]; // Last sampled inputs for edge detect
	unit_cfg_t cfg_q [UNITS]; // Programmed state
	ack_phase_t phase_q; // Which acknowledge comes next
	logic [2:0] ack_chan_q [UNITS]; // Channel taken at first acknowledge
	logic [UNITS-1:0] ack_took_q; // Unit set a service bit
	logic slave_hit_q; // Slave owns the vector

	// ------------------------------------------------------------
	// Combinational nets
	// ------------------------------------------------------------
	logic [7:0] req_in [UNITS]; // Channel request inputs
	logic [UNITS-1:0] unit_int; // Unit request outputs
	logic [UNITS-1:0] rq_found, is_found;
	logic [2:0] rq_chan [UNITS];
	logic [2:0] rq_rank [UNITS];
	logic [2:0] is_chan [UNITS];
	logic [2:0] is_rank [UNITS];
	logic [7:0] eligible [UNITS];
	logic [7:0] isr_eff [UNITS];
	logic first_ack, second_ack;
	logic [2:0] take_chan [UNITS]; // Channel chosen this first acknowledge
	logic [UNITS-1:0] take; // Unit sets a service bit now
	logic slave_hit; // Cascade code matched slave identifier

	// Slave output feeds master channel 2 directly
	assign req_in[0] = {ext_req_in[7:3], unit_int[1], ext_req_in[1], timer_out0_in};
	assign req_in[1] = {ext_req_in[15:9], rtc_irq_in};

	assign first_ack = ack_in && (phase_q == ACK_FIRST);
	assign second_ack = ack_in && (phase_q == ACK_SECOND);

	// ------------------------------------------------------------
	// Per-unit resolver and registers
	// ------------------------------------------------------------
	genvar u;
	generate
		for (u = 0; u < UNITS; u++) begin : g_unit
			logic wr_even, wr_odd; // Decoded writes
			logic [7:0] edge_set; // Newly latched requests
			logic [7:0] cmd_clr; // Service bits cleared by command
			logic [7:0] auto_clr; // Service bit cleared by auto done
			logic cmd_rot; // Command moves the lowest channel
			logic [2:0] cmd_low; // New lowest from command
			logic [2:0] op_ch; // Channel field of word two

			assign wr_even = io_wr_in && unit_hit(io_addr_in, u) && !io_addr_in[0];
			assign wr_odd = io_wr_in && unit_hit(io_addr_in, u) && io_addr_in[0];
			assign op_ch = io_wdata_in[2:0];
			// Masked service bits stop blocking in special mask mode
			assign eligible[u] = irr_q[u] & ~imr_q[u];
			assign isr_eff[u] = cfg_q[u].smm ? (isr_q[u] & ~imr_q[u]) : isr_q[u];

			irq_priority_pick u_req_pick (
				.vec_in(eligible[u]),
				.lowest_in(cfg_q[u].lowest),
				.found_out(rq_found[u]),
				.chan_out(rq_chan[u]),
				.rank_out(rq_rank[u])
			);
			irq_priority_pick u_isr_pick (
				.vec_in(isr_eff[u]),
				.lowest_in(cfg_q[u].lowest),
				.found_out(is_found[u]),
				.chan_out(is_chan[u]),
				.rank_out(is_rank[u])
			);

			// Strictly better rank needed: equal or lower is blocked
			assign unit_int[u] = rq_found[u] && (!is_found[u] || rq_rank[u] < is_rank[u]);

			// Edge mode latches rising inputs, level mode follows highs
			assign edge_set = cfg_q[u].ltm ? req_in[u] : (req_in[u] & ~prev_q[u]);

			// Operation word two decode
			always_comb begin
				cmd_clr = 8'h00;
				cmd_rot = 1'b0;
				cmd_low = cfg_q[u].lowest;
				if (wr_even && !io_wdata_in[INIT_BIT] && !io_wdata_in[SEL3_BIT]) begin
					unique case ({io_wdata_in[ROT_BIT], io_wdata_in[SPEC_BIT],
						io_wdata_in[DONE_BIT]})
						// Non-specific done, highest unshielded bit
						3'b001: begin
							cmd_clr = is_found[u] ? onehot(is_chan[u]) : 8'h00;
						end
						// Specific done
						3'b011: begin
							cmd_clr = onehot(op_ch);
						end
						// Rotate on non-specific done
						3'b101: begin
							cmd_clr = is_found[u] ? onehot(is_chan[u]) : 8'h00;
							cmd_rot = is_found[u];
							cmd_low = is_chan[u];
						end
						// Specific rotate
						3'b110: begin
							cmd_rot = 1'b1;
							cmd_low = op_ch;
						end
						// Rotate on specific done
						3'b111: begin
							cmd_clr = onehot(op_ch);
							cmd_rot = 1'b1;
							cmd_low = op_ch;
						end
						// Rotate-on-auto set/clear and no-op
						default: begin
							cmd_clr = 8'h00;
						end
					endcase
				end
			end

			// Auto done at trailing end of second acknowledge
			assign auto_clr = (second_ack && cfg_q[u].auto_service_done_mode && ack_took_q[u]) ?
				onehot(ack_chan_q[u]) : 8'h00;

			// Pending set: new requests win over the acknowledge clear
			always_ff @(posedge ref_clk_in or posedge rst_in) begin
				if (rst_in) begin
					irr_q[u] <= SET_RESET;
					prev_q[u] <= SET_RESET;
				end else if (clk_en_in) begin
					prev_q[u] <= req_in[u];
					irr_q[u] <= ((irr_q[u] & ~(take[u] ? onehot(take_chan[u]) : 8'h00))
						& (cfg_q[u].ltm ? req_in[u] : 8'hFF)) | edge_set;
				end
			end

			// In-service set: acknowledge set wins over clears
			always_ff @(posedge ref_clk_in or posedge rst_in) begin
				if (rst_in) begin
					isr_q[u] <= SET_RESET;
				end else if (clk_en_in) begin
					isr_q[u] <= (isr_q[u] & ~cmd_clr & ~auto_clr) |
						(take[u] ? onehot(take_chan[u]) : 8'h00);
				end
			end

			// Mask set and programmed state
			always_ff @(posedge ref_clk_in or posedge rst_in) begin
				if (rst_in) begin
					imr_q[u] <= SET_RESET;
					cfg_q[u] <= CFG_RESET;
				end else if (clk_en_in) begin
					if (wr_even && io_wdata_in[INIT_BIT]) begin
						// Init restarts fixed priority and clears masks
						imr_q[u] <= SET_RESET;
						cfg_q[u].lowest <= LOWEST_RESET;
						cfg_q[u].ltm <= io_wdata_in[LTM_BIT];
						cfg_q[u].smm <= 1'b0;
						cfg_q[u].rd_isr <= 1'b0;
						cfg_q[u].rot_auto_service_done_mode <= 1'b0;
						cfg_q[u].step <= 2'h3;
					end else if (wr_even) begin
						// Any operation word ends an unfinished init
						cfg_q[u].step <= 2'h0;
						if (io_wdata_in[SEL3_BIT]) begin
							if (io_wdata_in[ESMM_BIT]) begin
								cfg_q[u].smm <= io_wdata_in[SMM_BIT];
							end
							if (io_wdata_in[RR_BIT]) begin
								cfg_q[u].rd_isr <= io_wdata_in[RIS_BIT];
							end
						end else begin
							if (!io_wdata_in[SPEC_BIT] && !io_wdata_in[DONE_BIT]) begin
								cfg_q[u].rot_auto_service_done_mode <= io_wdata_in[ROT_BIT];
							end
							if (cmd_rot) begin
								cfg_q[u].lowest <= cmd_low;
							end
						end
					end else if (wr_odd) begin
						unique case (cfg_q[u].step)
							2'h3: cfg_q[u].vbase <= io_wdata_in[7:3];
							2'h2: cfg_q[u].id <= io_wdata_in[2:0];
							2'h1: cfg_q[u].auto_service_done_mode <= !io_wdata_in[AUTO_SERVICE_DONE_MODE_BIT];
							2'h0: imr_q[u] <= io_wdata_in;
						endcase
						if (cfg_q[u].step != 2'h0) begin
							cfg_q[u].step <= cfg_q[u].step - 2'h1;
						end
					end
					// Auto rotation when the auto done fires
					if (auto_clr != 8'h00 && cfg_q[u].rot_auto_service_done_mode) begin
						cfg_q[u].lowest <= ack_chan_q[u];
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// First acknowledge: choose channels and cascade owner
	// ------------------------------------------------------------
	always_comb begin
		// Nothing pending at the master gives channel 7, no service bit
		take[0] = first_ack && unit_int[0];
		take_chan[0] = unit_int[0] ? rq_chan[0] : SPURIOUS_CHAN;
		// Master channel 2 puts code 2 out; slave compares its identifier
		slave_hit = unit_int[0] && (rq_chan[0] == CASCADE_CHAN) &&
			(cfg_q[1].id == CASCADE_CHAN);
		take[1] = first_ack && slave_hit && unit_int[1];
		take_chan[1] = unit_int[1] ? rq_chan[1] : SPURIOUS_CHAN;
	end

	// ------------------------------------------------------------
	// Acknowledge sequence tracker
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			phase_q <= ACK_FIRST;
			ack_chan_q[0] <= SPURIOUS_CHAN;
			ack_chan_q[1] <= SPURIOUS_CHAN;
			ack_took_q <= '0;
			slave_hit_q <= 1'b0;
		end else if (clk_en_in) begin
			if (first_ack) begin
				phase_q <= ACK_SECOND;
				ack_chan_q[0] <= take_chan[0];
				ack_chan_q[1] <= take_chan[1];
				ack_took_q <= take;
				slave_hit_q <= slave_hit;
			end else if (second_ack) begin
				phase_q <= ACK_FIRST;
			end
		end
	end

	// ------------------------------------------------------------
	// Host data bus and request output, all registered
	// ------------------------------------------------------------
	// Bus stays off during first acknowledge; vector one cycle after second
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			host_data_bus_out <= 8'h00;
			host_data_oe_out <= 1'b0;
			cpu_request_out <= 1'b0;
		end else if (clk_en_in) begin
			cpu_request_out <= unit_int[0];
			host_data_oe_out <= 1'b0;
			host_data_bus_out <= 8'h00;
			if (second_ack) begin
				host_data_oe_out <= 1'b1;
				host_data_bus_out <= slave_hit_q ? {cfg_q[1].vbase, ack_chan_q[1]} :
					{cfg_q[0].vbase, ack_chan_q[0]};
			end else if (io_rd_in) begin
				for (int k = 0; k < UNITS; k++) begin
					if (unit_hit(io_addr_in, k)) begin
						host_data_oe_out <= 1'b1;
						host_data_bus_out <= io_addr_in[0] ? imr_q[k] :
							(cfg_q[k].rd_isr ? isr_q[k] : irr_q[k]);
					end
				end
			end
		end
	end
endmodule

`default_nettype wire

// ### irq_ctrl_properties.sv
// Port-level assertions for the cascaded interrupt controller
`default_nettype none
module irq_ctrl_properties (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	// Host port
	input wire logic [9:0] io_addr_in,
	input wire logic io_wr_in,
	input wire logic io_rd_in,
	input wire logic ack_in,
	// Outputs
	input wire logic [7:0] host_data_bus_out,
	input wire logic host_data_oe_out,
	input wire logic cpu_request_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Acknowledge phase tracking
	// ------------------------------------------------------------
	logic phase_q; // High between first and second acknowledge
	logic mapped; // Address hits one of the four ports
	assign mapped = io_addr_in inside {10'h020, 10'h021, 10'h0A0, 10'h0A1};
	// Toggles on each taken pulse; a frozen clock enable holds it
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			phase_q <= 1'b0;
		end else if (ack_in && clk_en_in) begin
			phase_q <= ~phase_q;
		end
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in || !clk_en_in);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	a_oe_has_cause: assert property (host_data_oe_out |-> $past(io_rd_in) || $past(ack_in))
		else $error("Bus driven without read or acknowledge");
	a_idle_bus_zero: assert property (!host_data_oe_out |-> host_data_bus_out == 8'h00)
		else $error("Bus carries data while not enabled");
	a_read_answered: assert property (io_rd_in && mapped |=> host_data_oe_out)
		else $error("Mapped read not answered");
	a_unmapped_silent: assert property (io_rd_in && !mapped && !ack_in |=> !host_data_oe_out)
		else $error("Unmapped read answered");
	a_first_ack_quiet: assert property (ack_in && !phase_q && !io_rd_in |=> !host_data_oe_out)
		else $error("First acknowledge drove the bus");
	a_second_ack_vector: assert property (ack_in && phase_q |=> host_data_oe_out)
		else $error("Second acknowledge gave no vector");
	a_write_silent: assert property (io_wr_in && !ack_in |=> !host_data_oe_out)
		else $error("Write drove the bus");
	a_reset_quiet: assert property ($fell(rst_in) |-> !cpu_request_out && !host_data_oe_out)
		else $error("Outputs active after reset");
endmodule
`default_nettype wire

// ### host_cpu_model.sv
// Host processor model: port writes, reads and acknowledge sequences
`default_nettype none
module host_cpu_model (
	// Clock
	input wire logic ref_clk_in,
	// Host port towards the controller
	output var logic [9:0] io_addr_out,
	output var logic [7:0] io_wdata_out,
	output var logic io_wr_out,
	output var logic io_rd_out,
	output var logic ack_out,
	// Returned data
	input wire logic [7:0] bus_in,
	input wire logic oe_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle port at time zero
	initial begin
		io_addr_out = 10'h000;
		io_wdata_out = 8'h00;
		io_wr_out = 1'b0;
		io_rd_out = 1'b0;
		ack_out = 1'b0;
	end
	// One-cycle write; data inverted after so stale bytes never match
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		io_addr_out <= a;
		io_wdata_out <= d;
		io_wr_out <= 1'b1;
		@(posedge ref_clk_in);
		io_wr_out <= 1'b0;
		io_wdata_out <= ~d;
	endtask
	// One-cycle read, data taken in the cycle after
	task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic v);
		@(posedge ref_clk_in);
		io_addr_out <= a;
		io_rd_out <= 1'b1;
		@(posedge ref_clk_in);
		io_rd_out <= 1'b0;
		@(posedge ref_clk_in);
		d = bus_in;
		v = oe_in;
	endtask
	// Two back-to-back acknowledge pulses, vector after the second
	task automatic acknowledge_cycle(output logic [7:0] d, output logic v);
		@(posedge ref_clk_in);
		ack_out <= 1'b1;
		@(posedge ref_clk_in);
		@(posedge ref_clk_in);
		ack_out <= 1'b0;
		@(posedge ref_clk_in);
		d = bus_in;
		v = oe_in;
	endtask
	// Four-word start-up sequence for one unit
	task automatic init(input logic [9:0] b, input logic [7:0] vb, input logic [7:0] w3,
		input logic [7:0] w4);
		wr(b, 8'h10);
		wr(b + 10'h001, vb);
		wr(b + 10'h001, w3);
		wr(b + 10'h001, w4);
	endtask
endmodule
`default_nettype wire

// ### cascaded_irq_controller_tb.sv
// Self-checking bench for the cascaded interrupt controller
`default_nettype none
module cascaded_irq_controller_tb import irq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [9:0] MO = MASTER_BASE + 10'h001; // Master odd port
	localparam logic [9:0] SO = SLAVE_BASE + 10'h001; // Slave odd port
	logic ref_clk_in = 1'b0; // 40 MHz clock
	logic rst_in = 1'b1; // Held three cycles
	logic clk_en_in = 1'b1; // Running except for the freeze in t_extra
	logic timer_out0_in = 1'b0;
	logic rtc_irq_in = 1'b0;
	logic [15:0] ext_req_in = 16'h0000;
	logic [9:0] io_addr_in;
	logic [7:0] io_wdata_in;
	logic io_wr_in;
	logic io_rd_in;
	logic ack_in;
	logic [7:0] host_data_bus_out;
	logic host_data_oe_out;
	logic cpu_request_out;
	int n_errors = 0;
	int cmp_count = 0;
	logic [7:0] d; // Returned byte
	logic v; // Returned enable
	always #12.5 ref_clk_in = ~ref_clk_in;
	cascaded_irq_controller dut (.ref_clk_in, .rst_in, .clk_en_in, .timer_out0_in, .rtc_irq_in,
		.ext_req_in, .io_addr_in, .io_wdata_in, .io_wr_in, .io_rd_in, .ack_in,
		.host_data_bus_out, .host_data_oe_out, .cpu_request_out);
	host_cpu_model host (.ref_clk_in, .io_addr_out(io_addr_in), .io_wdata_out(io_wdata_in),
		.io_wr_out(io_wr_in), .io_rd_out(io_rd_in), .ack_out(ack_in),
		.bus_in(host_data_bus_out), .oe_in(host_data_oe_out));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Set request lines, then let the cascade settle
	task automatic drive(input logic [15:0] r, input logic t, input logic c);
		@(posedge ref_clk_in);
		ext_req_in <= r;
		timer_out0_in <= t;
		rtc_irq_in <= c;
		repeat (6) @(posedge ref_clk_in);
	endtask
	task automatic reqchk(input logic e);
		chk({7'h00, cpu_request_out}, {7'h00, e});
	endtask
	task automatic vec(input logic [7:0] e);
		host.acknowledge_cycle(d, v);
		chk(d, e);
		chk({7'h00, v}, 8'h01);
	endtask
	task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
		host.rd(a, d, v);
		chk(d, e);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rdchk(MO, 8'h00);
		host.rd(10'h022, d, v);
		chk({7'h00, v}, 8'h00);
		host.init(MASTER_BASE, 8'h08, 8'h04, 8'h02);
		host.init(SLAVE_BASE, 8'h70, 8'h02, 8'h02);
		host.wr(SO, 8'hFF);
		rdchk(SO, 8'hFF);
		host.wr(SO, 8'h00);
		$display("reset test done");
	endtask
	// Fixed priority, nesting and both done commands
	task automatic t_fixed();
		drive(16'h0028, 1'b0, 1'b0);
		reqchk(1'b1);
		vec(8'h0B);
		reqchk(1'b0);
		drive(16'h0028, 1'b1, 1'b0);
		reqchk(1'b1);
		vec(8'h08);
		host.wr(MASTER_BASE, 8'h0B);
		rdchk(MASTER_BASE, 8'h09);
		host.wr(MASTER_BASE, 8'h20);
		rdchk(MASTER_BASE, 8'h08);
		host.wr(MASTER_BASE, 8'h63);
		rdchk(MASTER_BASE, 8'h00);
		reqchk(1'b1);
		vec(8'h0D);
		host.wr(MASTER_BASE, 8'h20);
		drive(16'h0000, 1'b0, 1'b0);
		vec(8'h0F);
		rdchk(MASTER_BASE, 8'h00);
		$display("fixed priority test done");
	endtask
	// Every external and RTC request pin through its unit, slave via cascade code
	task automatic t_cascade();
		for (int i = 1; i < 16; i++) begin
			if (i == 2 || i == 8) continue;
			drive(16'h0001 << i, 1'b0, 1'b0);
			vec(i < 8 ? 8'h08 + 8'(i) : 8'h68 + 8'(i));
			host.wr(SLAVE_BASE, 8'h20);
			host.wr(MASTER_BASE, 8'h20);
			drive(16'h0000, 1'b0, 1'b0);
		end
		drive(16'h0000, 1'b0, 1'b1);
		vec(8'h70);
		host.wr(SLAVE_BASE, 8'h20);
		host.wr(MASTER_BASE, 8'h20);
		$display("cascade test done");
	endtask
	// Mask, specific rotation, then auto done with rotation
	task automatic t_modes();
		host.wr(MO, 8'h20);
		drive(16'h0020, 1'b0, 1'b0);
		reqchk(1'b0);
		host.wr(MO, 8'h00);
		rdchk(MO, 8'h00);
		vec(8'h0D);
		host.wr(MASTER_BASE, 8'h20);
		host.wr(MASTER_BASE, 8'hC5);
		drive(16'h0082, 1'b0, 1'b0);
		vec(8'h0F);
		host.wr(MASTER_BASE, 8'h67);
		vec(8'h09);
		host.wr(MASTER_BASE, 8'h61);
		host.wr(MO, 8'hFF);
		host.init(MASTER_BASE, 8'h08, 8'h04, 8'h00);
		rdchk(MO, 8'h00);
		host.wr(MASTER_BASE, 8'h80);
		host.wr(MASTER_BASE, 8'h0B);
		drive(16'h0018, 1'b0, 1'b0);
		vec(8'h0B);
		rdchk(MASTER_BASE, 8'h00);
		drive(16'h0010, 1'b0, 1'b0);
		drive(16'h0018, 1'b0, 1'b0);
		vec(8'h0C);
		$display("modes test done");
	endtask
	// Mid-run reset, clock-enable freeze, then special mask shielding
	task automatic t_extra();
		drive(16'h0000, 1'b0, 1'b0);
		@(posedge ref_clk_in);
		rst_in <= 1'b1;
		@(posedge ref_clk_in);
		rst_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		reqchk(1'b0);
		host.init(MASTER_BASE, 8'h08, 8'h04, 8'h02);
		// Frozen block must neither latch nor raise a request
		clk_en_in <= 1'b0;
		drive(16'h0008, 1'b0, 1'b0);
		reqchk(1'b0);
		clk_en_in <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		reqchk(1'b1);
		vec(8'h0B);
		// Masked channel 3 in service no longer blocks channel 4
		host.wr(MASTER_BASE, 8'h6B);
		host.wr(MO, 8'h08);
		drive(16'h0018, 1'b0, 1'b0);
		reqchk(1'b1);
		vec(8'h0C);
		host.wr(MASTER_BASE, 8'h20);
		rdchk(MASTER_BASE, 8'h08);
		$display("reset and special mask test done");
	endtask
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Watchdog: the tests need well under 20000 cycles
	initial begin
		#(25 * 20000);
		n_errors++;
		end_of_test();
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_fixed();
		t_cascade();
		t_modes();
		t_extra();
		end_of_test();
	end
endmodule
bind cascaded_irq_controller irq_ctrl_properties chk (.ref_clk_in, .rst_in, .clk_en_in,
	.io_addr_in, .io_wr_in, .io_rd_in, .ack_in, .host_data_bus_out, .host_data_oe_out,
	.cpu_request_out);
`default_nettype wire
